// ---- rtl/mck_main_clock_switch_control.sv ----
// main system clock selection, switchover, cpu divider and standby control
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`include "mck_consts.svh"

// What this block does
// - internal osc register: stable bit7, stop bit0
// - halt keeps the active source record
// - crystal switch suspends cpu clock 4.06
// - external switch suspends 160 external ticks
// - three bit divider field sets cpu ratio
// - divider change waits old clocks, 16 to 1
// - select bit0: 0 internal, 1 system
// - source switch completes within computed old clocks
// - status bit1 reports running source
// - system enable bit2 changes once per reset
// - osc mode bits 7,6,0; stop bit 7
// - reset runs cpu from internal oscillator
module mck_main_clock_switch_control #(
  parameter int INT_HS_KHZ = 8000,   // internal oscillator rate
  parameter int HS_SYS_KHZ = 10000   // high-speed system clock rate
) (
  input  wire logic                     ref_clk,        // 250 MHz system clock
  input  wire logic                     rst,            // synchronous reset, high
  input  wire mck_pkg::mck_apb_req_type apbReq,         // apb request group
  output mck_pkg::mck_apb_rsp_type      apbRsp,         // apb answer group
  input  wire logic                     intHsTick,      // internal oscillator edge pulse
  input  wire logic                     hsSysTick,      // system clock edge pulse
  input  wire logic                     hsOscStable,    // internal oscillator settled
  input  wire logic                     haltReq,        // cpu executes halt
  input  wire logic                     stopReq,        // cpu executes stop
  input  wire logic                     wakeReq,        // release from halt or stop
  output logic                          cpuClkEn,       // cpu clock enable pulse
  output logic                          intOscEnable,   // run internal oscillator
  output logic                          mainOscEnable,  // run crystal or input buffer
  output logic                          extClkMode,     // pin takes external clock
  output logic                          xtalHighRange,  // amplifier high range
  output logic                          mainClkActive,  // cpu runs on system clock
  output logic                          haltActive,     // halt state
  output logic                          stopActive      // stop state
);
  import mck_pkg::*;

  // old-clock counts for each switch direction, fraction dropped
  localparam int UP_CNT = 1 + (2 * INT_HS_KHZ) / HS_SYS_KHZ;
  localparam int DN_CNT = 1 + (2 * HS_SYS_KHZ) / INT_HS_KHZ;

  // counters are eight bits wide; refuse rates they cannot hold
  if (INT_HS_KHZ < 1 || HS_SYS_KHZ < 1 || UP_CNT > 255 || DN_CNT > 255) begin : g_chk
    $error("mck: oscillator rates give a switch count beyond 255");
  end

  localparam mck_state_type RESET_ST = '{
    mainOscStop : `MCK_RST_MOSC_STOP,
    divSel      : `MCK_RST_DIV,
    divAct      : `MCK_RST_DIV,
    pwr         : PWR_RUN,
    default     : '0
  };

  mck_state_type st_reg;   // all block state
  mck_state_type st_next;  // its next value

  logic        srcTick;    // edge of the source the cpu runs from
  logic        running;    // cpu allowed to clock
  logic        tickNow;    // cpu edge this cycle
  logic [3:0]  divMask;    // divider compare mask
  logic        apbSetup;   // setup phase
  logic        apbAccess;  // access phase
  logic        addrHit;    // address is mapped
  logic [31:0] rdMux;      // read data for the addressed word

  // address decode and read data selection
  always_comb begin
    rdMux   = 32'h0000_0000;
    addrHit = 1'b1;
    case (apbReq.paddr)
      `MCK_OFF_IOSC_MODE: begin
        rdMux[`MCK_BIT_HS_STABLE] = hsOscStable;
        rdMux[`MCK_BIT_HS_STOP]   = st_reg.hsOscStop;
      end
      `MCK_OFF_OSC_MODE: begin
        rdMux[`MCK_BIT_EXT_SEL]  = st_reg.extClkSel;
        rdMux[`MCK_BIT_PIN_SEL]  = st_reg.oscPinSel;
        rdMux[`MCK_BIT_AMP_HIGH] = st_reg.ampHigh;
      end
      `MCK_OFF_MOSC_CTRL: rdMux[`MCK_BIT_MOSC_STOP] = st_reg.mainOscStop;
      `MCK_OFF_MCLK_MODE: begin
        rdMux[`MCK_BIT_SYS_EN] = st_reg.hsSysEn;
        rdMux[`MCK_BIT_STATUS] = st_reg.mainClkStatus;
        rdMux[`MCK_BIT_SELECT] = st_reg.mainClkSel;
      end
      `MCK_OFF_CPU_CTRL: rdMux[2:0] = st_reg.divSel;
      default: addrHit = 1'b0;  // unmapped word reads zero and errors
    endcase
  end

  // next-state logic: divider, switchover, suspension, standby, registers
  always_comb begin
    st_next   = st_reg;
    apbSetup  = apbReq.psel && !apbReq.penable;
    apbAccess = apbReq.psel && apbReq.penable;
    // the cpu keeps the old source until the switch really completes
    srcTick   = st_reg.mainClkStatus ? hsSysTick : intHsTick;
    divMask   = 4'hF >> (`MCK_DIV_MAX - st_reg.divAct);
    running   = (st_reg.pwr == PWR_RUN) && (st_reg.suspCnt == 11'h000);
    tickNow   = srcTick && ((st_reg.divCnt & divMask) == divMask) && running;
    st_next.cpuTick = tickNow;
    if (srcTick) begin
      st_next.divCnt = st_reg.divCnt + 4'h1;
    end
    // divider change lands on a cpu edge so no short period appears
    if (st_reg.divPend && tickNow) begin
      if (st_reg.divWait == 5'h01) begin
        st_next.divAct  = st_reg.divSel;
        st_next.divPend = 1'b0;
        st_next.divCnt  = 4'h0;
      end else begin
        st_next.divWait = st_reg.divWait - 5'h01;
      end
    end
    // suspension counts ref clocks for crystal, else edges of the running source
    if (st_reg.suspCnt != 11'h000 && (!st_reg.suspOnSys || srcTick)) begin
      st_next.suspCnt = st_reg.suspCnt - 11'h001;
    end
    // source switchover, counted in edges of the old source
    if (!st_reg.swPend) begin
      if (st_reg.mainClkSel != st_reg.mainClkStatus) begin
        st_next.swPend = 1'b1;
        st_next.swCnt  = st_reg.mainClkSel ? 8'(UP_CNT) : 8'(DN_CNT);
      end
    end else if (st_reg.mainClkSel == st_reg.mainClkStatus) begin
      st_next.swPend = 1'b0;  // select reverted before completion
    end else if (srcTick) begin
      if (st_reg.swCnt == 8'h01) begin
        st_next.swPend        = 1'b0;
        st_next.mainClkStatus = st_reg.mainClkSel;
        st_next.divCnt        = 4'h0;
        if (st_reg.mainClkSel) begin
          st_next.suspOnSys = st_reg.extClkSel;
          st_next.suspCnt   = st_reg.extClkSel ? 11'(`MCK_EXT_SUSP_TICKS)
                                               : 11'(`MCK_XTAL_SUSP_CYC);
        end else begin
          // the last old edge already clocked the cpu; skip the first new edge
          st_next.suspOnSys = 1'b1;
          st_next.suspCnt   = 11'h001;
        end
      end else begin
        st_next.swCnt = st_reg.swCnt - 8'h01;
      end
    end
    // standby states leave the source record untouched
    case (st_reg.pwr)
      PWR_RUN: begin
        if (stopReq) begin
          st_next.pwr = PWR_STOP;
        end else if (haltReq) begin
          st_next.pwr = PWR_HALT;
        end
      end
      PWR_HALT, PWR_STOP: begin
        if (wakeReq) begin
          st_next.pwr = PWR_RUN;
        end
      end
      default: st_next.pwr = PWR_RUN;
    endcase
    // read data is captured in setup so it comes from a flop in access
    if (apbSetup) begin
      st_next.prdata = rdMux;
    end
    if (apbAccess && apbReq.pwrite) begin
      case (apbReq.paddr)
        `MCK_OFF_IOSC_MODE: st_next.hsOscStop = apbReq.pwdata[`MCK_BIT_HS_STOP];
        `MCK_OFF_OSC_MODE: begin
          st_next.extClkSel = apbReq.pwdata[`MCK_BIT_EXT_SEL];
          st_next.oscPinSel = apbReq.pwdata[`MCK_BIT_PIN_SEL];
          st_next.ampHigh   = apbReq.pwdata[`MCK_BIT_AMP_HIGH];
        end
        `MCK_OFF_MOSC_CTRL: st_next.mainOscStop = apbReq.pwdata[`MCK_BIT_MOSC_STOP];
        `MCK_OFF_MCLK_MODE: begin
          // the enable bit accepts a single change per reset
          if (!st_reg.xselUsed && apbReq.pwdata[`MCK_BIT_SYS_EN] != st_reg.hsSysEn) begin
            st_next.hsSysEn  = apbReq.pwdata[`MCK_BIT_SYS_EN];
            st_next.xselUsed = 1'b1;
          end
          // selecting the system clock without its enable is ignored
          if (!apbReq.pwdata[`MCK_BIT_SELECT] || st_reg.hsSysEn) begin
            st_next.mainClkSel = apbReq.pwdata[`MCK_BIT_SELECT];
          end
        end
        `MCK_OFF_CPU_CTRL: begin
          // ratios above the largest are not served and are dropped
          if (apbReq.pwdata[2:0] <= `MCK_DIV_MAX) begin
            st_next.divSel  = apbReq.pwdata[2:0];
            st_next.divPend = apbReq.pwdata[2:0] != st_reg.divAct;
            st_next.divWait = `MCK_DIV_WAIT_BASE >> st_reg.divAct;
          end
        end
        default: ;
      endcase
    end
  end

  // single state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= RESET_ST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs; a stop bit never stops the oscillator the cpu runs on
  always_comb begin
    apbRsp.prdata  = st_reg.prdata;
    apbRsp.pready  = 1'b1;
    apbRsp.pslverr = apbAccess && !addrHit;
    cpuClkEn       = st_reg.cpuTick;
    intOscEnable   = (st_reg.pwr != PWR_STOP)
                     && (!st_reg.hsOscStop || !st_reg.mainClkStatus);
    mainOscEnable  = (st_reg.pwr != PWR_STOP) && st_reg.oscPinSel
                     && (!st_reg.mainOscStop || st_reg.mainClkStatus);
    extClkMode     = st_reg.extClkSel;
    xtalHighRange  = st_reg.ampHigh;
    mainClkActive  = st_reg.mainClkStatus;
    haltActive     = st_reg.pwr == PWR_HALT;
    stopActive     = st_reg.pwr == PWR_STOP;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_to_sys;
    $rose(st_reg.mainClkStatus);
  endsequence

  a_status_on_switch: assert property ($changed(st_reg.mainClkStatus) |->
    $past(st_reg.swPend) && $past(st_reg.swCnt) == 8'h01) else $error("status moved early");
  a_xtal_suspend: assert property (s_to_sys ##0 !st_reg.suspOnSys |->
    ##1 !cpuClkEn [*8]) else $error("cpu clocked during crystal suspension");
  a_ext_suspend: assert property (s_to_sys ##0 st_reg.suspOnSys |->
    st_reg.suspCnt == 11'd160 ##1 !cpuClkEn) else $error("external suspension wrong");
  a_div_delay: assert property ($changed(st_reg.divAct) |->
    $past(st_reg.divPend) && $past(st_reg.divWait) == 5'h01) else $error("divider early");
  a_sysen_once: assert property ($past(st_reg.xselUsed) |->
    $stable(st_reg.hsSysEn)) else $error("enable changed twice");
  a_halt_hold: assert property (haltActive ##1 haltActive |->
    !cpuClkEn && $stable(st_reg.mainClkStatus)) else $error("halt let clock run");
  a_reset_int: assert property ($past(rst) |->
    !mainClkActive && intOscEnable) else $error("reset not on internal clock");
  a_clean_change: assert property ($changed(st_reg.divAct) || $changed(st_reg.mainClkStatus)
    |-> st_reg.divCnt == 4'h0 ##1 !cpuClkEn) else $error("short cpu period");
  a_switch_bound: assert property (st_reg.swPend |->
    st_reg.swCnt <= 8'(UP_CNT > DN_CNT ? UP_CNT : DN_CNT)) else $error("switch count too big");
  a_osc_keep: assert property (!mainClkActive && !stopActive |->
    intOscEnable) else $error("running oscillator stopped");
endmodule

// ---- common/mck_consts.svh ----
// constants for the main clock switch control block
`ifndef MCK_CONSTS_SVH
`define MCK_CONSTS_SVH
`define MCK_ADDR_W          8
`define MCK_OFF_IOSC_MODE   8'h00
`define MCK_OFF_OSC_MODE    8'h04
`define MCK_OFF_MOSC_CTRL   8'h08
`define MCK_OFF_MCLK_MODE   8'h0C
`define MCK_OFF_CPU_CTRL    8'h10
`define MCK_BIT_HS_STABLE   7
`define MCK_BIT_HS_STOP     0
`define MCK_BIT_EXT_SEL     7
`define MCK_BIT_PIN_SEL     6
`define MCK_BIT_AMP_HIGH    0
`define MCK_BIT_MOSC_STOP   7
`define MCK_BIT_SYS_EN      2
`define MCK_BIT_STATUS      1
`define MCK_BIT_SELECT      0
`define MCK_RST_MOSC_STOP   1'b1
`define MCK_RST_DIV         3'h0
`define MCK_DIV_MAX         3'h4
`define MCK_DIV_WAIT_BASE   5'h10
`define MCK_CLK_PERIOD_NS   4
`define MCK_XTAL_SUSP_NS    4060
`define MCK_XTAL_SUSP_CYC   ((`MCK_XTAL_SUSP_NS + `MCK_CLK_PERIOD_NS - 1) / `MCK_CLK_PERIOD_NS)
`define MCK_EXT_SUSP_TICKS  160
`endif

// ---- common/mck_pkg.sv ----
// types for the main clock switch control block
package mck_pkg;
  typedef enum logic [1:0] {
    PWR_RUN  = 2'h0,
    PWR_HALT = 2'h1,
    PWR_STOP = 2'h3
  } mck_pwr_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } mck_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mck_apb_rsp_type;

  typedef struct packed {
    logic        hsOscStop;
    logic        extClkSel;
    logic        oscPinSel;
    logic        ampHigh;
    logic        mainOscStop;
    logic        hsSysEn;
    logic        xselUsed;
    logic        mainClkSel;
    logic        mainClkStatus;
    logic [2:0]  divSel;
    logic [2:0]  divAct;
    logic        divPend;
    logic [4:0]  divWait;
    logic [3:0]  divCnt;
    logic        swPend;
    logic [7:0]  swCnt;
    logic [10:0] suspCnt;
    logic        suspOnSys;
    mck_pwr_type pwr;
    logic [31:0] prdata;
    logic        cpuTick;
  } mck_state_type;
endpackage

// ---- verif/mck_osc_model.sv ----
// oscillator sources model: tick pulses and settle flag for the internal oscillator
`timescale 1ns/1ps
module mck_osc_model #(
  parameter int INT_DIV = 31,  // ref cycles per internal oscillator period
  parameter int SYS_DIV = 25,  // ref cycles per system clock period
  parameter int SETTLE  = 4    // ref cycles before the internal oscillator is settled
) (
  input  wire logic ref_clk,        // bench clock
  input  wire logic intOscEnable,   // internal oscillator runs
  input  wire logic mainOscEnable,  // crystal or input buffer runs
  output logic      intHsTick,      // internal oscillator edge pulse
  output logic      hsSysTick,      // system clock edge pulse
  output logic      hsOscStable     // internal oscillator settled
);
  int intCnt = 0;  // phase of the internal oscillator
  int sysCnt = 0;  // phase of the system clock
  int setCnt = 0;  // settle time since enable
  // a stopped source gives no ticks and loses its settled state
  always_ff @(posedge ref_clk) begin
    if (intOscEnable !== 1'b1) begin
      intCnt <= 0;
      setCnt <= 0;
    end else begin
      intCnt <= (intCnt == INT_DIV - 1) ? 0 : intCnt + 1;
      if (setCnt < SETTLE) setCnt <= setCnt + 1;
    end
    sysCnt <= (mainOscEnable !== 1'b1 || sysCnt == SYS_DIV - 1) ? 0 : sysCnt + 1;
  end
  assign intHsTick   = (intOscEnable === 1'b1) && (intCnt == INT_DIV - 1);
  assign hsSysTick   = (mainOscEnable === 1'b1) && (sysCnt == SYS_DIV - 1);
  assign hsOscStable = (setCnt >= SETTLE);
endmodule

// ---- verif/mck_main_clock_switch_control_tb.sv ----
// self-checking bench for the main clock switch control block
`timescale 1ns/1ps
module mck_main_clock_switch_control_tb;
  import mck_pkg::*;
  typedef struct packed {
    logic [7:0]  addr;    // register offset
    logic [31:0] rstVal;  // value after reset
    logic [31:0] wData;   // value written
    logic [31:0] rdVal;   // value read back
    logic        err;     // slave error expected
  } mck_row_type;
  logic            ref_clk;
  logic            rst;
  mck_apb_req_type apbReq;
  mck_apb_rsp_type apbRsp;
  logic            intHsTick, hsSysTick, hsOscStable;
  logic [2:0]      cpuReq;  // halt, stop, wake pulses
  logic            cpuClkEn, intOscEnable, mainOscEnable, extClkMode;
  logic            xtalHighRange, mainClkActive, haltActive, stopActive;
  int              errors, checked, n, k;
  logic [31:0]     r;
  logic            e;
  // select write with the enable bit clear is refused, divider above 4 ignored
  mck_row_type rows [6] = '{
    '{8'h00, 32'h80, 32'hFF, 32'h81, 1'b0}, '{8'h04, 32'h00, 32'hC1, 32'hC1, 1'b0},
    '{8'h08, 32'h80, 32'h00, 32'h00, 1'b0}, '{8'h0C, 32'h00, 32'h01, 32'h00, 1'b0},
    '{8'h10, 32'h00, 32'h05, 32'h00, 1'b0}, '{8'h14, 32'h00, 32'hFF, 32'h00, 1'b1}};
  mck_main_clock_switch_control i_dut (.ref_clk(ref_clk), .rst(rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .intHsTick(intHsTick), .hsSysTick(hsSysTick),
    .hsOscStable(hsOscStable), .haltReq(cpuReq[0]), .stopReq(cpuReq[1]),
    .wakeReq(cpuReq[2]), .cpuClkEn(cpuClkEn), .intOscEnable(intOscEnable),
    .mainOscEnable(mainOscEnable), .extClkMode(extClkMode), .xtalHighRange(xtalHighRange),
    .mainClkActive(mainClkActive), .haltActive(haltActive), .stopActive(stopActive));
  mck_osc_model i_osc (.ref_clk(ref_clk), .intOscEnable(intOscEnable),
    .mainOscEnable(mainOscEnable), .intHsTick(intHsTick), .hsSysTick(hsSysTick),
    .hsOscStable(hsOscStable));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge ref_clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (apbRsp.pready !== 1'b1 && t < 50);
    if (apbRsp.pready !== 1'b1) begin
      errors++;
      summarize();
    end
    r = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    // the write lands at the ready edge; let it reach the outputs first
    @(posedge ref_clk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, r, x);
  endtask
  // counts edges until the condition holds; a spent bound ends the run
  task automatic waitFor(input int sel, input int lim, output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (c < lim && (sel == 0 ? cpuClkEn : mainClkActive === sel[1]) !== 1'b1);
    if (c >= lim) begin
      errors++;
      summarize();
    end
  endtask
  task automatic pulse(input int i);
    @(posedge ref_clk);
    cpuReq[i] <= 1'b1;
    @(posedge ref_clk);
    cpuReq <= 3'h0;
    @(posedge ref_clk);
  endtask
  initial begin
    rst = 1'b1;
    apbReq = '0;
    cpuReq = 3'h0;
    errors = 0;
    checked = 0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    chk("status", mainClkActive, 0);
    // reset values, then write and read back each register
    foreach (rows[i]) begin
      rdc("rstval", rows[i].addr, rows[i].rstVal);
      apb(1'b1, rows[i].addr, rows[i].wData);
      rdc("rdback", rows[i].addr, rows[i].rdVal);
      chk("slverr", e, rows[i].err);
    end
    $display("test registers done");
    apb(1'b1, 8'h04, 32'h40);
    chk("xtalMode", {extClkMode, xtalHighRange}, 0);
    repeat (100) @(posedge ref_clk);
    apb(1'b1, 8'h0C, 32'h04);
    apb(1'b1, 8'h0C, 32'h05);
    chk("earlyStatus", mainClkActive, 0);
    waitFor(2, 300, n);
    chk("upTime", n <= 2 * 31 + 4, 1);
    waitFor(0, 3000, n);
    chk("suspend", n >= 1015 && n <= 1015 + 60, 1);
    rdc("mode", 8'h0C, 32'h07);
    apb(1'b1, 8'h0C, 32'h01);
    rdc("sysOnce", 8'h0C, 32'h07);
    chk("intOff", intOscEnable, 0);
    $display("test switch up done");
    apb(1'b1, 8'h10, 32'h04);
    k = 0;
    do begin
      waitFor(0, 600, n);
      k++;
    end while (n < 100 && k < 20);
    chk("divGap", n, 400);
    chk("divDelay", k >= 15 && k <= 18, 1);
    apb(1'b1, 8'h10, 32'h00);
    $display("test divider done");
    pulse(0);
    chk("halt", {haltActive, mainClkActive}, 3);
    repeat (60) begin
      @(posedge ref_clk);
      chk("haltTick", cpuClkEn, 0);
    end
    pulse(2);
    chk("wake", haltActive, 0);
    $display("test halt done");
    apb(1'b1, 8'h00, 32'h00);
    k = 0;
    do begin
      apb(1'b0, 8'h00, 32'h0);
      k++;
    end while (r[7] !== 1'b1 && k < 20);
    chk("stable", r[7], 1'b1);
    apb(1'b1, 8'h0C, 32'h04);
    waitFor(1, 300, n);
    chk("dnTime", n <= 3 * 25 + 6, 1);
    apb(1'b1, 8'h08, 32'h80);
    chk("mainOff", {mainOscEnable, intOscEnable}, 1);
    $display("test switch down done");
    // nothing else runs here, so stop needs no peripheral shutdown first
    pulse(1);
    chk("stop", {stopActive, intOscEnable}, 2);
    pulse(2);
    chk("stopWake", stopActive, 0);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rdc("reReset", 8'h0C, 32'h00);
    // external input: pin, enable and amplifier set, then select the system clock
    apb(1'b1, 8'h04, 32'hC1);
    apb(1'b1, 8'h08, 32'h00);
    apb(1'b1, 8'h0C, 32'h04);
    apb(1'b1, 8'h0C, 32'h05);
    waitFor(2, 300, n);
    waitFor(0, 5000, n);
    chk("extSuspend", n >= 3990 && n <= 4040, 1);
    $display("test stop and reset done");
    summarize();
  end
endmodule
